//--- src/mem_if.sv
// port bundle between the control logic and the management memory
`timescale 1ns/1ps
interface mem_if;
   import mgmt_pkg::*;
   logic [MEM_AW-1:0] addr;
   logic [7:0] wdata;
   logic we;
   logic [7:0] rdata;
   modport ctrl (output addr, output wdata, output we, input rdata);
   modport ram (input addr, input wdata, input we, output rdata);
endinterface : mem_if

//--- src/mgmt_ctrl.sv
// module management: reset, low power, latched flags, interrupt, squelch, serial memory
// How it works
// - reset pin low for at least 2 us starts a full module reset
// - after reset pin release the module is ready within the init time
// - after power-on or reset the module is ready within 2000 ms
// - serial bus answers once initialization finishes, within 2000 ms
// - init completion clears not-ready bit 0 of byte 2 and raises interrupt
// - low-power select forces power level 1 on the next cycle
// - any unmasked pending flag drives the interrupt low next cycle
// - reading a flag clears it and releases the interrupt two cycles later
// - receive loss latches its flag and raises the interrupt
// - transmit fault latches its flag and raises the interrupt
// - transmit loss flags latch and raise the interrupt alike
// - a set mask bit removes its flag from the interrupt
// - a cleared mask bit lets its flag raise the interrupt again
// - power-down bit forces power level 1
// - clearing power-down restores full operation
// - receive loss squelches that receive output; recovery restores it
// - transmit input loss squelches that transmit output; recovery restores it
// - transmit disable bit turns the transmit output off and back on
// - receive disable bit turns the receive output off and back on
// - squelch disable bits stop squelch; clearing them resumes it
// - one bus address, fixed lower 128 bytes, paged upper 128 bytes
// - per-channel flags latch on condition and clear when read
// - with module select high the serial bus is never acknowledged
// - reset completion posts an interrupt with not-ready negated, also at power-up
// - low-power select high holds low power, low runs normally
`timescale 1ns/1ps
module mgmt_ctrl
   import mgmt_pkg::*;
#(
   parameter int P_INIT_MS = INIT_MAX_MS
)
(
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_MODULE_RESET_LOW_INPUT,
   input wire logic I_LOW_POWER_SELECT,
   input wire logic I_MODULE_SELECT_LOW,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic [NCH-1:0] I_RX_LOS,
   input wire logic [NCH-1:0] I_TX_LOS,
   input wire logic [NCH-1:0] I_TX_FAULT,
   output logic O_SDA_OUT,
   output logic O_SDA_OE_N,
   output logic O_INTERRUPT_LOW_OUTPUT,
   output logic O_INTERRUPT_LOW_OUTPUT_OE_N,
   output logic O_LOW_POWER,
   output logic O_READY,
   output logic [NCH-1:0] O_TX_ENABLE,
   output logic [NCH-1:0] O_RX_ENABLE,
   output logic [NCH-1:0] O_TX_SQUELCH,
   output logic [NCH-1:0] O_RX_SQUELCH
);
   localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(P_INIT_MS - 1);

   mem_if mp ();

   mgmt_ram u_ram (
      .i_clk(I_CLK),
      .mp(mp.ram)
   );

   // pin synchronisers: three flops, a change counts when the last two agree
   logic [NPIN-1:0] pin_r1_q, pin_r2_q, pin_r3_q, pin_q, pin_d, pin_raw;
   assign pin_raw = {I_TX_FAULT, I_TX_LOS, I_RX_LOS, I_SDA, I_SCL, I_MODULE_SELECT_LOW,
                     I_LOW_POWER_SELECT, I_MODULE_RESET_LOW_INPUT};

   always_comb
   begin
      pin_d = (pin_q & (pin_r2_q ^ pin_r3_q)) | (pin_r3_q & ~(pin_r2_q ^ pin_r3_q));
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         pin_r1_q <= PIN_IDLE;
         pin_r2_q <= PIN_IDLE;
         pin_r3_q <= PIN_IDLE;
         pin_q <= PIN_IDLE;
      end
      else
      begin
         pin_r1_q <= pin_raw;
         pin_r2_q <= pin_r1_q;
         pin_r3_q <= pin_r2_q;
         pin_q <= pin_d;
      end
   end

   // timebase, reset pulse qualification and initialization
   logic [US_CNT_W-1:0] us_cnt_q, us_cnt_d;
   logic [MS_CNT_W-1:0] ms_cnt_q, ms_cnt_d;
   logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
   logic [INIT_CNT_W-1:0] init_cnt_q, init_cnt_d;
   logic init_busy_q, init_busy_d;
   logic us_tick, ms_tick, mod_rst, init_done;

   always_comb
   begin
      us_tick = (us_cnt_q == US_LAST);
      ms_tick = us_tick && (ms_cnt_q == MS_LAST);
      us_cnt_d = us_tick ? '0 : us_cnt_q + 1'b1;
      ms_cnt_d = ms_cnt_q;
      if (ms_tick)
         ms_cnt_d = '0;
      else if (us_tick)
         ms_cnt_d = ms_cnt_q + 1'b1;
      rst_cnt_d = '0;
      if (!pin_q[PIN_RST])
         rst_cnt_d = (rst_cnt_q == RST_MIN_CNT) ? rst_cnt_q : rst_cnt_q + 1'b1;
      mod_rst = !pin_q[PIN_RST] && (rst_cnt_q == RST_MIN_CNT);
      // a pin reset held across a tick keeps init busy and posts nothing
      init_done = init_busy_q && ms_tick && (init_cnt_q == INIT_LAST) && !mod_rst;
      init_busy_d = init_busy_q;
      init_cnt_d = init_cnt_q;
      if (mod_rst)
      begin
         init_busy_d = 1'b1;
         init_cnt_d = '0;
      end
      else if (init_done)
         init_busy_d = 1'b0;
      else if (init_busy_q && ms_tick)
         init_cnt_d = init_cnt_q + 1'b1;
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         us_cnt_q <= '0;
         ms_cnt_q <= '0;
         rst_cnt_q <= '0;
         init_cnt_q <= '0;
         init_busy_q <= 1'b1;
      end
      else
      begin
         us_cnt_q <= us_cnt_d;
         ms_cnt_q <= ms_cnt_d;
         rst_cnt_q <= rst_cnt_d;
         init_cnt_q <= init_cnt_d;
         init_busy_q <= init_busy_d;
      end
   end

   // serial slave, control bytes, flags and interrupt
   twi_e st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, page_q, page_d, rd_val;
   logic rw_q, rw_d, hp_q, hp_d, drv_q, drv_d, nack_q, nack_d;
   logic scl_p_q, sda_p_q, scl_rise, scl_fall, start, stop, wr_now, ld_now;
   logic [NFLAG-1:0] flags_q, flags_d, mask_q, mask_d, clr;
   logic [NCH-1:0] txdis_q, txdis_d, rxdis_q, rxdis_d, txsqd_q, txsqd_d, rxsqd_q, rxsqd_d;
   logic pdown_q, pdown_d, initf_q, initf_d, irq_q, irq_d, lp_q, lp_d, rdy_q, rdy_d;

   always_comb
   begin
      rd_val = mp.rdata;
      case (ptr_q)
         ADR_STATUS: rd_val = {6'h00, irq_q, init_busy_q};
         ADR_LOS: rd_val = flags_q[2*NCH-1:0];
         ADR_FAULT: rd_val = {4'h0, flags_q[NFLAG-1:2*NCH]};
         ADR_TXDIS: rd_val = {4'h0, txdis_q};
         ADR_PDOWN: rd_val = {7'h00, pdown_q};
         ADR_MASK_LOS: rd_val = mask_q[2*NCH-1:0];
         ADR_MASK_FLT: rd_val = {4'h0, mask_q[NFLAG-1:2*NCH]};
         ADR_PAGE: rd_val = page_q;
         ADR_SQDIS: if (page_q == PAGE_CTRL) rd_val = {rxsqd_q, txsqd_q};
         ADR_RXDIS: if (page_q == PAGE_CTRL) rd_val = {rxdis_q, 4'h0};
         default: rd_val = mp.rdata;
      endcase
   end

   always_comb
   begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      page_d = page_q;
      rw_d = rw_q;
      hp_d = hp_q;
      drv_d = drv_q;
      nack_d = nack_q;
      txdis_d = txdis_q;
      rxdis_d = rxdis_q;
      txsqd_d = txsqd_q;
      rxsqd_d = rxsqd_q;
      pdown_d = pdown_q;
      mask_d = mask_q;
      clr = '0;
      wr_now = 1'b0;
      ld_now = 1'b0;
      scl_rise = pin_q[PIN_SCL] && !scl_p_q;
      scl_fall = !pin_q[PIN_SCL] && scl_p_q;
      start = pin_q[PIN_SCL] && scl_p_q && sda_p_q && !pin_q[PIN_SDA];
      stop = pin_q[PIN_SCL] && scl_p_q && !sda_p_q && pin_q[PIN_SDA];
      if (stop || pin_q[PIN_MSEL])
      begin
         st_d = S_IDLE;
         drv_d = 1'b0;
      end
      else if (start)
      begin
         st_d = init_busy_q ? S_IDLE : S_ADDR;
         bit_d = '0;
         hp_d = 1'b0;
         drv_d = 1'b0;
      end
      else if (scl_rise)
      begin
         case (st_q)
            S_ADDR, S_WR:
            begin
               sh_d = {sh_q[6:0], pin_q[PIN_SDA]};
               bit_d = bit_q + 1'b1;
            end
            S_RD: bit_d = bit_q + 1'b1;
            S_RACK: nack_d = pin_q[PIN_SDA];
            default: bit_d = bit_q;
         endcase
      end
      else if (scl_fall)
      begin
         case (st_q)
            S_ADDR:
               if (bit_q == BITS_PER_BYTE)
               begin
                  st_d = (sh_q[7:1] == DEV_ADDR) ? S_ACK : S_IDLE;
                  drv_d = (sh_q[7:1] == DEV_ADDR);
                  rw_d = sh_q[0];
               end
            S_ACK:
            begin
               bit_d = '0;
               drv_d = 1'b0;
               st_d = rw_q ? S_RD : S_WR;
               ld_now = rw_q;
            end
            S_WR:
               if (bit_q == BITS_PER_BYTE)
               begin
                  wr_now = 1'b1;
                  st_d = S_ACK;
                  drv_d = 1'b1;
                  hp_d = 1'b1;
                  ptr_d = hp_q ? ptr_q + 1'b1 : sh_q;
               end
            S_RD:
               if (bit_q == BITS_PER_BYTE)
               begin
                  drv_d = 1'b0;
                  st_d = S_RACK;
               end
               else
               begin
                  drv_d = ~tx_q[7];
                  tx_d = {tx_q[6:0], 1'b0};
               end
            S_RACK:
            begin
               bit_d = '0;
               st_d = nack_q ? S_IDLE : S_RD;
               ld_now = !nack_q;
            end
            default: st_d = S_IDLE;
         endcase
      end
      if (ld_now)
      begin
         tx_d = {rd_val[6:0], 1'b0};
         drv_d = ~rd_val[7];
         ptr_d = ptr_q + 1'b1;
         if (ptr_q == ADR_LOS)
            clr[2*NCH-1:0] = rd_val;
         if (ptr_q == ADR_FAULT)
            clr[NFLAG-1:2*NCH] = rd_val[NCH-1:0];
      end
      if (wr_now && hp_q)
      begin
         case (ptr_q)
            ADR_TXDIS: txdis_d = sh_q[NCH-1:0];
            ADR_PDOWN: pdown_d = sh_q[0];
            ADR_MASK_LOS: mask_d[2*NCH-1:0] = sh_q;
            ADR_MASK_FLT: mask_d[NFLAG-1:2*NCH] = sh_q[NCH-1:0];
            ADR_PAGE: page_d = sh_q;
            ADR_SQDIS: if (page_q == PAGE_CTRL) {rxsqd_d, txsqd_d} = sh_q;
            ADR_RXDIS: if (page_q == PAGE_CTRL) rxdis_d = sh_q[7:NCH];
            default: page_d = page_q;
         endcase
      end
      if (mod_rst)
      begin
         st_d = S_IDLE;
         drv_d = 1'b0;
         page_d = '0;
         txdis_d = '0;
         rxdis_d = '0;
         txsqd_d = '0;
         rxsqd_d = '0;
         pdown_d = 1'b0;
         mask_d = '0;
      end
      // a condition present in the clearing cycle keeps its flag set
      flags_d = (flags_q & ~clr) | pin_q[NPIN-1:PIN_RXLOS];
      initf_d = init_done | (initf_q & ~(ld_now && ptr_q == ADR_STATUS));
      irq_d = (|(flags_q & ~mask_q)) | initf_q;
      lp_d = pin_q[PIN_LPM] | pdown_q;
      rdy_d = !lp_d && !init_busy_q;
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         st_q <= S_IDLE;
         bit_q <= '0;
         sh_q <= '0;
         tx_q <= '0;
         ptr_q <= '0;
         page_q <= '0;
         rw_q <= 1'b0;
         hp_q <= 1'b0;
         drv_q <= 1'b0;
         nack_q <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         flags_q <= '0;
         mask_q <= '0;
         txdis_q <= '0;
         rxdis_q <= '0;
         txsqd_q <= '0;
         rxsqd_q <= '0;
         pdown_q <= 1'b0;
         initf_q <= 1'b0;
         irq_q <= 1'b0;
         lp_q <= 1'b0;
         rdy_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         page_q <= page_d;
         rw_q <= rw_d;
         hp_q <= hp_d;
         drv_q <= drv_d;
         nack_q <= nack_d;
         scl_p_q <= pin_q[PIN_SCL];
         sda_p_q <= pin_q[PIN_SDA];
         flags_q <= flags_d;
         mask_q <= mask_d;
         txdis_q <= txdis_d;
         rxdis_q <= rxdis_d;
         txsqd_q <= txsqd_d;
         rxsqd_q <= rxsqd_d;
         pdown_q <= pdown_d;
         initf_q <= initf_d;
         irq_q <= irq_d;
         lp_q <= lp_d;
         rdy_q <= rdy_d;
      end
   end

   assign mp.addr = {ptr_q[UPPER_BIT], ptr_q[UPPER_BIT] ? page_q[1:0] : 2'b00, ptr_q[6:0]};
   assign mp.wdata = sh_q;
   assign mp.we = wr_now && hp_q;

   // per-channel output path; a fault holds the transmitter off until disable toggles
   logic [NCH-1:0] fh_q, fh_d, txen_q, txen_d, rxen_q, rxen_d, txsq_q, txsq_d, rxsq_q, rxsq_d;
   genvar c;
   generate
      for (c = 0; c < NCH; c++)
      begin : g_ch
         always_comb
         begin
            fh_d[c] = pin_q[PIN_TXFLT+c] | (fh_q[c] & ~(txdis_q[c] & ~txdis_d[c]) & ~mod_rst);
            rxsq_d[c] = pin_q[PIN_RXLOS+c] & ~rxsqd_q[c];
            txsq_d[c] = pin_q[PIN_TXLOS+c] & ~txsqd_q[c];
            txen_d[c] = ~txdis_q[c] & ~fh_q[c] & ~lp_d & ~init_busy_q;
            rxen_d[c] = ~rxdis_q[c] & ~lp_d & ~init_busy_q;
         end
      end
   endgenerate

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         fh_q <= '0;
         txen_q <= '0;
         rxen_q <= '0;
         txsq_q <= '0;
         rxsq_q <= '0;
      end
      else
      begin
         fh_q <= fh_d;
         txen_q <= txen_d;
         rxen_q <= rxen_d;
         txsq_q <= txsq_d;
         rxsq_q <= rxsq_d;
      end
   end

   assign O_SDA_OUT = 1'b0;
   assign O_SDA_OE_N = ~(drv_q & ~pin_q[PIN_MSEL]);
   assign O_INTERRUPT_LOW_OUTPUT = 1'b0;
   assign O_INTERRUPT_LOW_OUTPUT_OE_N = ~irq_q;
   assign O_LOW_POWER = lp_q;
   assign O_READY = rdy_q;
   assign O_TX_ENABLE = txen_q;
   assign O_RX_ENABLE = rxen_q;
   assign O_TX_SQUELCH = txsq_q;
   assign O_RX_SQUELCH = rxsq_q;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   chk_reset_pulse: assert property (mod_rst |=> init_busy_q ##1 !O_READY)
      else $error("qualified reset pulse did not restart init");
   chk_init_done: assert property (init_done |=> !init_busy_q && initf_q ##1 !O_INTERRUPT_LOW_OUTPUT_OE_N && O_READY == !lp_q)
      else $error("init completion not posted");
   chk_lp_entry: assert property ($rose(pin_q[PIN_LPM]) |=> O_LOW_POWER ##1 !O_READY)
      else $error("low power select not honoured");
   chk_pdown_exit: assert property ($fell(pdown_q) && !pin_q[PIN_LPM] && !init_busy_q |=> ##1 O_READY)
      else $error("power-down exit not ready");
   chk_pdown_entry: assert property (pdown_q |=> O_LOW_POWER && !O_TX_ENABLE[0])
      else $error("power-down not honoured");
   chk_los_latch: assert property (pin_q[PIN_RXLOS] && !mask_q[0] |=> flags_q[0] ##1 !O_INTERRUPT_LOW_OUTPUT_OE_N)
      else $error("receive loss not latched or not signalled");
   chk_fault_latch: assert property (pin_q[PIN_TXFLT] |=> flags_q[2*NCH] && fh_q[0] ##1 !O_TX_ENABLE[0])
      else $error("transmit fault not latched");
   chk_irq_masked: assert property ((flags_q & ~mask_q) == '0 && !initf_q |=> O_INTERRUPT_LOW_OUTPUT_OE_N)
      else $error("interrupt active with nothing pending");
   chk_irq_unmask: assert property ((|(flags_q & ~mask_q)) |=> !O_INTERRUPT_LOW_OUTPUT_OE_N)
      else $error("unmasked flag did not interrupt");
   chk_rx_squelch: assert property (pin_q[PIN_RXLOS+1] && !rxsqd_q[1] |=> O_RX_SQUELCH[1])
      else $error("receive squelch missing");
   chk_tx_squelch: assert property (!pin_q[PIN_TXLOS+2] || txsqd_q[2] |=> !O_TX_SQUELCH[2])
      else $error("transmit squelch not released");
   chk_tx_disable: assert property (txdis_q[3] |=> !O_TX_ENABLE[3])
      else $error("transmit disable ignored");
   chk_rx_disable: assert property (rxdis_q[2] |=> !O_RX_ENABLE[2])
      else $error("receive disable ignored");
   chk_deselect_quiet: assert property (pin_q[PIN_MSEL] |-> O_SDA_OE_N ##1 st_q == S_IDLE)
      else $error("bus driven while deselected");
   chk_ms_tick: assert property (ms_tick |-> us_tick ##1 ms_cnt_q == '0 && us_cnt_q == '0)
      else $error("timebase out of step");
   chk_busy_no_bus: assert property (init_busy_q && start |=> st_q == S_IDLE)
      else $error("bus answered during init");
endmodule : mgmt_ctrl

//--- src/mgmt_pkg.sv
// constants shared by the module management block and its memory
package mgmt_pkg;
   // clock and timebase
   localparam int CLK_HZ = 100_000_000;
   localparam int US_PER_S = 1_000_000;
   localparam int CYC_PER_US = CLK_HZ / US_PER_S;
   localparam int US_PER_MS = 1000;
   localparam int US_CNT_W = 7;
   localparam int MS_CNT_W = 10;
   localparam logic [US_CNT_W-1:0] US_LAST = US_CNT_W'(CYC_PER_US - 1);
   localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(US_PER_MS - 1);
   // reset pin pulse and initialization
   localparam int RST_MIN_US = 2;
   localparam int RST_MIN_CYC = RST_MIN_US * CYC_PER_US;
   localparam int RST_CNT_W = 8;
   localparam logic [RST_CNT_W-1:0] RST_MIN_CNT = RST_CNT_W'(RST_MIN_CYC);
   localparam int INIT_MAX_MS = 2000;
   localparam int INIT_CNT_W = 11;
   // channels and synchronised pins
   localparam int NCH = 4;
   localparam int NFLAG = 3 * NCH;
   localparam int PIN_RST = 0;
   localparam int PIN_LPM = 1;
   localparam int PIN_MSEL = 2;
   localparam int PIN_SCL = 3;
   localparam int PIN_SDA = 4;
   localparam int PIN_RXLOS = 5;
   localparam int PIN_TXLOS = PIN_RXLOS + NCH;
   localparam int PIN_TXFLT = PIN_TXLOS + NCH;
   localparam int NPIN = PIN_TXFLT + NCH;
   localparam logic [NPIN-1:0] PIN_IDLE = 17'h0001d;
   // serial bus
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // management memory byte addresses
   localparam logic [7:0] ADR_STATUS = 8'h02;
   localparam logic [7:0] ADR_LOS = 8'h03;
   localparam logic [7:0] ADR_FAULT = 8'h04;
   localparam logic [7:0] ADR_TXDIS = 8'h56;
   localparam logic [7:0] ADR_PDOWN = 8'h5d;
   localparam logic [7:0] ADR_MASK_LOS = 8'h64;
   localparam logic [7:0] ADR_MASK_FLT = 8'h65;
   localparam logic [7:0] ADR_PAGE = 8'h7f;
   localparam logic [7:0] ADR_SQDIS = 8'hf0;
   localparam logic [7:0] ADR_RXDIS = 8'hf1;
   localparam logic [7:0] PAGE_CTRL = 8'h03;
   localparam int UPPER_BIT = 7;
   localparam int MEM_AW = 10;
   localparam int MEM_DEPTH = 1 << MEM_AW;
   // serial slave states, gray along the usual path except S_ACK to S_RD
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ADDR = 3'h1,
      S_ACK = 3'h3,
      S_WR = 3'h2,
      S_RD = 3'h6,
      S_RACK = 3'h4
   } twi_e;
endpackage : mgmt_pkg

//--- src/mgmt_ram.sv
// paged management memory with registered read data
`timescale 1ns/1ps
module mgmt_ram
   import mgmt_pkg::*;
(
   input wire logic i_clk,
   mem_if.ram mp
);
   logic [7:0] mem_q [0:MEM_DEPTH-1];
   logic [7:0] rdata_q;

   always_ff @(posedge i_clk)
   begin
      if (mp.we)
      begin
         mem_q[mp.addr] <= mp.wdata;
      end
      rdata_q <= mem_q[mp.addr];
   end

   assign mp.rdata = rdata_q;
endmodule : mgmt_ram

//--- verification/mgmt_ctrl_test.sv
// self-checking bench for the module management block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module mgmt_ctrl_test;
   import mgmt_pkg::*;
   typedef struct {logic [3:0] rx; logic [3:0] tx; logic [3:0] flt; logic [7:0] adr;
      logic [7:0] flag;} row_s;
   row_s rows[5] = '{'{4'h1, 4'h0, 4'h0, ADR_LOS, 8'h01}, '{4'ha, 4'h0, 4'h0, ADR_LOS, 8'h0a},
      '{4'h0, 4'h2, 4'h0, ADR_LOS, 8'h20}, '{4'h0, 4'h4, 4'h0, ADR_LOS, 8'h40},
      '{4'h0, 4'h0, 4'h1, ADR_FAULT, 8'h01}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mrst_n = 1'b1;
   logic lps = 1'b0;
   logic msel_n = 1'b0;
   logic [3:0] rx = 4'h0;
   logic [3:0] tx = 4'h0;
   logic [3:0] flt = 4'h0;
   logic scl, sda, sda_oe_n, int_oe_n, lp, rdy, ok, sda_out, int_out;
   logic [3:0] txe, rxe, txs, rxs;
   logic [7:0] d;
   int failures = 0;
   int comparisons = 0;
   initial forever #5 clk = ~clk;
   twi_host host (.i_clk(clk), .i_sda_oe_n(sda_oe_n), .o_scl(scl), .o_sda(sda));
   mgmt_ctrl #(.P_INIT_MS(1)) dut (.I_CLK(clk), .I_RST_N(rst_n),
      .I_MODULE_RESET_LOW_INPUT(mrst_n), .I_LOW_POWER_SELECT(lps),
      .I_MODULE_SELECT_LOW(msel_n), .I_SCL(scl), .I_SDA(sda), .I_RX_LOS(rx), .I_TX_LOS(tx),
      .I_TX_FAULT(flt), .O_SDA_OUT(sda_out), .O_SDA_OE_N(sda_oe_n),
      .O_INTERRUPT_LOW_OUTPUT(int_out),
      .O_INTERRUPT_LOW_OUTPUT_OE_N(int_oe_n), .O_LOW_POWER(lp), .O_READY(rdy),
      .O_TX_ENABLE(txe), .O_RX_ENABLE(rxe), .O_TX_SQUELCH(txs), .O_RX_SQUELCH(rxs));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done
   task automatic wrap_up;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   initial
   begin
      cyc(150000);
      failures++;
      wrap_up();
   end
   initial
   begin
      cyc(10);
      rst_n <= 1'b1;
      host.wr(ADR_TXDIS, 8'h01, ok);
      `CHK("early ack", 1'b0, ok)
      for (int i = 0; i < 120000 && rdy !== 1'b1; i++) cyc(1);
      cyc(4);
      `CHK("ready", 1'b1, rdy)
      `CHK("init irq", 1'b0, int_oe_n)
      `CHK("drive levels", 2'b00, {sda_out, int_out})
      host.rd(ADR_STATUS, d, ok);
      `CHK("not ready bit", 1'b0, d[0])
      cyc(20);
      `CHK("init irq off", 1'b1, int_oe_n)
      done("init");
      for (int r = 0; r < 5; r++)
      begin
         rx <= rows[r].rx;
         tx <= rows[r].tx;
         flt <= rows[r].flt;
         cyc(20);
         `CHK("irq on", 1'b0, int_oe_n)
         `CHK("squelch on", {rows[r].rx, rows[r].tx}, {rxs, txs})
         rx <= 4'h0;
         tx <= 4'h0;
         flt <= 4'h0;
         cyc(20);
         `CHK("squelch off", 8'h00, {rxs, txs})
         host.rd(rows[r].adr, d, ok);
         `CHK("ack", 1'b1, ok)
         `CHK("flag latched", rows[r].flag, d)
         cyc(20);
         `CHK("irq off", 1'b1, int_oe_n)
         host.rd(rows[r].adr, d, ok);
         `CHK("flag cleared", 8'h00, d)
      end
      done("flags");
      host.wr(ADR_MASK_FLT, 8'h01, ok);
      flt <= 4'h1;
      cyc(20);
      `CHK("fault masked", 1'b1, int_oe_n)
      flt <= 4'h0;
      host.rd(ADR_FAULT, d, ok);
      `CHK("masked fault", 8'h01, d)
      host.wr(ADR_MASK_FLT, 8'h00, ok);
      cyc(20);
      `CHK("fault unmasked", 1'b1, int_oe_n)
      `CHK("fault holds tx off", 4'he, txe)
      host.wr(ADR_TXDIS, 8'h01, ok);
      host.wr(ADR_TXDIS, 8'h00, ok);
      cyc(10);
      `CHK("tx restored", 4'hf, txe)
      host.wr(ADR_TXDIS, 8'h0a, ok);
      cyc(10);
      `CHK("tx disabled", 4'h5, txe)
      host.wr(ADR_TXDIS, 8'h00, ok);
      done("tx disable");
      host.wr(ADR_MASK_LOS, 8'h01, ok);
      rx <= 4'h1;
      cyc(20);
      `CHK("masked", 1'b1, int_oe_n)
      rx <= 4'h0;
      host.wr(ADR_MASK_LOS, 8'h00, ok);
      cyc(20);
      `CHK("unmasked", 1'b0, int_oe_n)
      host.rd(ADR_LOS, d, ok);
      `CHK("masked flag", 8'h01, d)
      done("mask");
      host.wr(ADR_PAGE, PAGE_CTRL, ok);
      host.wr(ADR_SQDIS, 8'h11, ok);
      host.wr(ADR_RXDIS, 8'h60, ok);
      rx <= 4'h1;
      tx <= 4'h1;
      cyc(20);
      `CHK("squelch disabled", 8'h00, {rxs, txs})
      `CHK("rx disabled", 4'h9, rxe)
      host.rd(ADR_SQDIS, d, ok);
      `CHK("upper page", 8'h11, d)
      host.wr(ADR_SQDIS, 8'h00, ok);
      host.wr(ADR_RXDIS, 8'h00, ok);
      cyc(10);
      `CHK("squelch resumed", 8'h11, {rxs, txs})
      `CHK("rx enabled", 4'hf, rxe)
      rx <= 4'h0;
      tx <= 4'h0;
      host.rd(ADR_LOS, d, ok);
      host.wr(ADR_PAGE, 8'h00, ok);
      done("squelch");
      lps <= 1'b1;
      cyc(10);
      `CHK("low power pin", 1'b1, lp)
      lps <= 1'b0;
      cyc(10);
      `CHK("normal", 2'b01, {lp, rdy})
      host.wr(ADR_PDOWN, 8'h01, ok);
      cyc(5);
      `CHK("power down", 1'b1, lp)
      host.wr(ADR_PDOWN, 8'h00, ok);
      cyc(5);
      `CHK("power up", 2'b01, {lp, rdy})
      done("power");
      msel_n <= 1'b1;
      host.wr(ADR_TXDIS, 8'h0f, ok);
      `CHK("deselected", 5'h0f, {ok, txe})
      msel_n <= 1'b0;
      mrst_n <= 1'b0;
      cyc(50);
      mrst_n <= 1'b1;
      cyc(10);
      `CHK("short pulse", 1'b1, rdy)
      // host holds the pin low past the minimum pulse
      mrst_n <= 1'b0;
      cyc(300);
      `CHK("module reset", 1'b0, rdy)
      done("pin reset");
      wrap_up();
   end
endmodule : mgmt_ctrl_test

//--- verification/twi_host.sv
// two-wire host model: serial clock and open-drain data line
`timescale 1ns/1ps
module twi_host
(
   input wire logic i_clk,
   input wire logic i_sda_oe_n,
   output logic o_scl,
   output logic o_sda
);
   logic pull_q = 1'b0;
   initial o_scl = 1'b1;
   // pulled up unless either side pulls low
   assign o_sda = ~pull_q & i_sda_oe_n;
   task automatic half;
      repeat (10) @(posedge i_clk);
   endtask : half
   // data moves 3 cycles after the clock falls, never while it is high
   task automatic bit_io(input logic b, output logic s);
      pull_q <= ~b;
      half();
      o_scl <= 1'b1;
      half();
      s = o_sda;
      o_scl <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask : bit_io
   task automatic start;
      pull_q <= 1'b0;
      half();
      o_scl <= 1'b1;
      half();
      pull_q <= 1'b1;
      half();
      o_scl <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask : start
   task automatic stop;
      pull_q <= 1'b1;
      half();
      o_scl <= 1'b1;
      half();
      pull_q <= 1'b0;
      half();
   endtask : stop
   task automatic send(input logic [7:0] b, inout logic ok);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ok = ok & ~s;
   endtask : send
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      ok = 1'b1;
      start();
      send(8'ha0, ok);
      send(a, ok);
      send(d, ok);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic s;
      ok = 1'b1;
      start();
      send(8'ha0, ok);
      send(a, ok);
      start();
      send(8'ha1, ok);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      // no acknowledge ends the read
      bit_io(1'b1, s);
      stop();
   endtask : rd
endmodule : twi_host
